// ==== hw/ldnc_top.sv ====
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// R01 - Mode zero: accumulation halts when the interval counter reaches terminal count.
// R02 - Mode one: continuous; at timeout integrator reloads and result latches for reading.
// R03 - Sixteen-bit interval field forms the upper bits of an 18-bit counter preload.
// R04 - Software picks period N, multiple of four, and programs N/4+1.
// R05 - Interpolated zeros are integrated; gated input reaccumulates the held sample each clock.
// R06 - Each integrated sample adds input magnitude to threshold, bits 12..0 aligned.
// R07 - Input threshold is a signed 14-bit value with bit 13 as sign.
// R08 - Any write to the start location starts or restarts the integrator.
// R09 - Oscillator takes a 32-bit frequency word spanning plus/minus half sample rate.
// R10 - Frequency word held until strobe, or enabled sync pulse, then copied active.
// R11 - Oscillator advances or updates only while the active-low input enable is low; the strobes here copy to the active registers regardless.
// R12 - A sync load arriving while not updating is remembered until next update.
// R13 - Carrier phase is offset by a 10-bit phase word, bit 9 MSB.
// R14 - Phase word works as two's complement or offset binary alike.
// R15 - Phase word held until phase strobe or enabled sync, then made active.
// R16 - Write to frequency strobe copies held frequency into active register.
// R17 - Write to phase strobe copies held phase into active register.
// R18 - Software writes zeros to all reserved bits.
// R19 - With load-on-update set, frequency update or sync load also zeros accumulator feedback.
// R20 - Sync pulse moves held values only when the external sync enable is one.
`include "ldnc_defs.svh"

module ldnc_top
   import ldnc_pkg::*;
#(
   parameter int ACC_W  = 32,
   parameter int ADDR_W = 8
) (
   // Clock, reset, enable
   input  wire logic              core_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   // APB slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Sample input side
   input  wire logic [13:0]       sample_i,
   input  wire logic              input_enable_n_i,
   input  wire logic              front_end_sync_input_i,
   // Results
   output logic      [9:0]        carrier_phase_o,
   output logic                   level_busy_o
);

   // Address decode shared by read and write paths
   // Unlisted and unaligned addresses map to no register, which the
   // handshake answers with an error and read data of zero.
   function automatic ldnc_reg_t ldnc_decode(input logic [ADDR_W-1:0] a);
      case (a)
         `LDNC_A_CTRL:    ldnc_decode = LDNC_R_CTRL;
         `LDNC_A_LDCFG:   ldnc_decode = LDNC_R_LDCFG;
         `LDNC_A_LDSTART: ldnc_decode = LDNC_R_LDSTART;
         `LDNC_A_FREQ:    ldnc_decode = LDNC_R_FREQ;
         `LDNC_A_PHASE:   ldnc_decode = LDNC_R_PHASE;
         `LDNC_A_FSTROBE: ldnc_decode = LDNC_R_FSTROBE;
         `LDNC_A_PSTROBE: ldnc_decode = LDNC_R_PSTROBE;
         `LDNC_A_RESULT:  ldnc_decode = LDNC_R_RESULT;
         `LDNC_A_STATUS:  ldnc_decode = LDNC_R_STATUS;
         `LDNC_A_AFREQ:   ldnc_decode = LDNC_R_AFREQ;
         default:         ldnc_decode = LDNC_R_NONE;
      endcase
   endfunction : ldnc_decode

   // Registers
   // Holding and active copies are kept apart so software can prepare
   // a new frequency or phase without disturbing the running carrier.
   ldnc_ctl_t          ctl_r;
   ldnc_ld_cfg_t       cfg_r;
   logic [31:0]        freq_hold_r;
   logic [31:0]        freq_act_r;
   logic [9:0]         po_hold_r;
   logic [9:0]         po_act_r;
   logic [31:0]        phase_acc_r;
   logic               sync_pend_r;
   logic               zero_pend_r;
   logic [17:0]        cnt_r;
   logic [ACC_W-1:0]   acc_r;
   logic [ACC_W-1:0]   result_r;
   logic [13:0]        held_r;
   ldnc_state_t        state_r;
   ldnc_state_t        state_nxt;

   // Bus strobes
   // A write takes effect only in the cycle its ready pulse is seen,
   // the same cycle in which the master takes its answer.
   logic               access;
   logic               done;
   logic               wr;
   ldnc_reg_t          sel;
   logic [31:0]        rd_val;

   assign access = psel_i & penable_i;
   assign done   = access & pready_o;
   assign wr     = done & pwrite_i;
   assign sel    = ldnc_decode(paddr_i);

   // Bus handshake: one wait state, then answer
   // The first access cycle only registers the answer, so read data comes
   // from a flip-flop and the decode path never reaches an output pin.
   // Ready lasts one cycle; a master that keeps penable high afterwards
   // starts a fresh wait. Error and read data hold until the next answer.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pready_o  <= 1'h0;
         pslverr_o <= 1'h0;
         prdata_o  <= `LDNC_RST_W32;
      end else if (ce_i) begin
         pready_o <= access & ~pready_o;
         if (access & ~pready_o) begin
            pslverr_o <= (sel == LDNC_R_NONE);
            prdata_o  <= pwrite_i ? `LDNC_RST_W32 : rd_val;
         end
      end
   end

   // Read mux
   // Holding registers read back as written; strobe and start locations
   // read as zero. Status packs the pending flags, detector state and the
   // top of the active phase word, so software can watch a sync in flight.
   always_comb begin
      rd_val = `LDNC_RST_W32;
      case (sel)
         LDNC_R_CTRL: begin
            rd_val[`LDNC_CTL_SYNC_EN]  = ctl_r.sync_en;
            rd_val[`LDNC_CTL_IN_FMT]   = ctl_r.in_fmt;
            rd_val[`LDNC_CTL_IN_MODE]  = ctl_r.in_mode;
            rd_val[`LDNC_CTL_CLR_ACC]  = ctl_r.clr_acc;
            rd_val[`LDNC_CTL_LOAD_UPD] = ctl_r.load_upd;
         end
         LDNC_R_LDCFG:  rd_val[`LDNC_CFG_MSB:0] = cfg_r;
         LDNC_R_FREQ:   rd_val = freq_hold_r;
         LDNC_R_PHASE:  rd_val[`LDNC_PO_MSB:0] = po_hold_r;
         LDNC_R_RESULT: rd_val = 32'(result_r);
         LDNC_R_STATUS: rd_val = {26'h0, zero_pend_r, sync_pend_r, state_r, po_act_r[9:8]};
         LDNC_R_AFREQ:  rd_val = freq_act_r;
         default:       rd_val = `LDNC_RST_W32;
      endcase
   end

   // Configuration registers
   // Only completed writes land here. Reserved bits are dropped on entry,
   // so a careless write cannot reach a field that does not exist.
   // Writes to the read-only locations fall through the default branch.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ctl_r       <= '0;
         cfg_r       <= '0;
         freq_hold_r <= `LDNC_RST_W32;
         po_hold_r   <= `LDNC_RST_PO;
      end else if (ce_i && wr) begin
         case (sel)
            LDNC_R_CTRL: begin
               ctl_r.sync_en  <= pwdata_i[`LDNC_CTL_SYNC_EN];
               ctl_r.in_fmt   <= pwdata_i[`LDNC_CTL_IN_FMT];
               ctl_r.in_mode  <= pwdata_i[`LDNC_CTL_IN_MODE];
               ctl_r.clr_acc  <= pwdata_i[`LDNC_CTL_CLR_ACC];
               ctl_r.load_upd <= pwdata_i[`LDNC_CTL_LOAD_UPD];
            end
            LDNC_R_LDCFG: cfg_r       <= pwdata_i[`LDNC_CFG_MSB:0];
            LDNC_R_FREQ:  freq_hold_r <= pwdata_i;                     // R09
            LDNC_R_PHASE: po_hold_r   <= pwdata_i[`LDNC_PO_MSB:0];    // R13
            default:      ;
         endcase
      end
   end

   // Oscillator control strobes
   // The enable pin gates every oscillator step. A sync pulse counts only
   // while the external sync enable bit is set; a counted pulse loads at
   // once when the oscillator steps, otherwise it waits in the pending flag.
   logic nco_upd;
   logic sync_req;
   logic fstb;
   logic pstb;
   logic sync_load;

   assign nco_upd   = ~input_enable_n_i;                                  // R11
   assign sync_req  = front_end_sync_input_i & ctl_r.sync_en;             // R20
   assign fstb      = wr & (sel == LDNC_R_FSTROBE);
   assign pstb      = wr & (sel == LDNC_R_PSTROBE);
   assign sync_load = nco_upd & (sync_req | sync_pend_r);                 // R12

   // Pending sync and feedback-zero requests
   // A request is parked only while the oscillator is idle; one that meets
   // a step is served in that cycle. Parking it as well would serve it a
   // second time on the next step and reload values written in between.
   // Set and clear therefore never meet, and no request is lost.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sync_pend_r <= 1'h0;
         zero_pend_r <= 1'h0;
      end else if (ce_i) begin
         sync_pend_r <= (sync_req | sync_pend_r) & ~nco_upd;              // R12
         zero_pend_r <= ((fstb & ctl_r.load_upd) | zero_pend_r) & ~nco_upd; // R19
      end
   end

   // Active frequency register
   // A strobe copies at once, whatever the enable pin does; a sync copy
   // waits for a step. Both take the holding value of that cycle.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         freq_act_r <= `LDNC_RST_W32;
      end else if (ce_i) begin
         if (fstb || sync_load) begin
            freq_act_r <= freq_hold_r;                                    // R10 R16
         end
      end
   end

   // Active phase offset register
   // Same timing as the frequency copy, so one sync moves both together.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         po_act_r <= `LDNC_RST_PO;
      end else if (ce_i) begin
         if (pstb || sync_load) begin
            po_act_r <= po_hold_r;                                        // R15 R17
         end
      end
   end

   // Phase accumulator and phase output
   // Feedback is zeroed while the clear bit is set, or on a frequency load
   // with load-on-update set; a strobe that meets an idle cycle waits.
   logic zero_fb;
   logic [31:0] acc_base;

   assign zero_fb  = ctl_r.clr_acc | ((sync_load | zero_pend_r | (fstb & nco_upd)) & ctl_r.load_upd); // R19
   assign acc_base = zero_fb ? `LDNC_RST_W32 : phase_acc_r;

   // Accumulator steps only on enabled cycles; zeroed feedback restarts it
   // from the frequency word alone, giving a known phase after a load.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         phase_acc_r <= `LDNC_RST_W32;
      end else if (ce_i && nco_upd) begin
         phase_acc_r <= acc_base + freq_act_r;                            // R11
      end
   end

   // Phase output: top accumulator bits plus the offset word
   // The sum wraps modulo the word size, so a two's complement offset and
   // an offset binary one give the same angle; no mode bit is needed.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         carrier_phase_o <= `LDNC_RST_PO;
      end else if (ce_i && nco_upd) begin
         carrier_phase_o <= acc_base[31:`LDNC_PH_TOP] + po_act_r;         // R13 R14
      end
   end

   // Sample selection for the level detector
   logic [13:0] samp_tc;
   logic [13:0] samp_use;
   logic [14:0] mag;
   logic signed [15:0] term;

   // Last enabled sample, reused while the input is gated off
   // so a gated run repeats real data and never sees the idle pin value
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i)
         held_r <= '0;
      else if (ce_i && nco_upd)
         held_r <= sample_i;
   end

   // Magnitude plus signed threshold, one term per integrated cycle
   // Interpolated zeros and repeated gated samples both count, so software
   // sizes interval and threshold with them in mind. The magnitude is one
   // bit wider than the sample so the most negative input does not wrap.
   always_comb begin
      // Interpolated: zero when not enabled; gated: held sample
      if (ctl_r.in_mode)
         samp_use = nco_upd ? sample_i : '0;                               // R05
      else
         samp_use = nco_upd ? sample_i : held_r;                           // R05
      // Offset binary becomes two's complement by flipping the top bit
      samp_tc = ctl_r.in_fmt ? {~samp_use[13], samp_use[12:0]} : samp_use;
      mag     = samp_tc[13] ? 15'(-{samp_tc[13], samp_tc}) : {1'h0, samp_tc};
      // Threshold sign-extends; its low bits line up with the sample's
      term    = signed'({1'h0, mag}) + 16'(signed'(cfg_r.threshold));    // R06 R07
   end

   // Level detector state and timeout
   // The counter runs down from the preload and times out at the value
   // that leaves exactly N integrated cycles for a preload of N/4+1.
   // A start write always wins, even in the timeout cycle, so a restart
   // is never swallowed by a one-shot that ends at that moment.
   logic start;
   logic tmo;
   logic [17:0] preload;

   assign start   = wr & (sel == LDNC_R_LDSTART);                          // R08
   assign preload = {cfg_r.interval, `LDNC_CNT_LSB_PAD};                   // R03 R04
   assign tmo     = (state_r == LDNC_RUN) & (cnt_r == `LDNC_CNT_TC);

   // Next state: idle, running, done
   always_comb begin
      case (state_r)
         LDNC_IDLE: state_nxt = start ? LDNC_RUN : LDNC_IDLE;
         LDNC_RUN:  state_nxt = (tmo & ~cfg_r.mode & ~start) ? LDNC_DONE : LDNC_RUN; // R01
         LDNC_DONE: state_nxt = start ? LDNC_RUN : LDNC_DONE;
         default:   state_nxt = LDNC_IDLE;
      endcase
   end

   // State register; busy comes from the next state so it is a
   // flip-flop output that matches the state in every cycle
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_r      <= LDNC_IDLE;
         level_busy_o <= 1'h0;
      end else if (ce_i) begin
         state_r      <= state_nxt;
         level_busy_o <= (state_nxt == LDNC_RUN);
      end
   end

   // Interval counter: loads on start, counts down while running
   // In continuous mode the timeout reloads it; in one-shot mode it rests.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cnt_r <= `LDNC_RST_CNT;
      end else if (ce_i) begin
         if (start) begin
            cnt_r <= preload;                                             // R08
         end else if (tmo) begin
            if (cfg_r.mode) begin
               cnt_r <= preload;                                          // R02
            end
         end else if (state_r == LDNC_RUN) begin
            cnt_r <= cnt_r - `LDNC_CNT_STEP;
         end
      end
   end

   // Integrator: cleared on start and on a continuous reload
   // A one-shot run stops adding once the counter has ended.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         acc_r <= '0;
      end else if (ce_i) begin
         if (start) begin
            acc_r <= '0;                                                  // R08
         end else if (tmo) begin
            if (cfg_r.mode) begin
               acc_r <= '0;                                               // R02
            end
         end else if (state_r == LDNC_RUN) begin
            acc_r <= acc_r + ACC_W'(term);                                // R06
         end
      end
   end

   // Result register: copied at each timeout without a start write, for software to read
   // It keeps the last finished interval while the next one runs.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         result_r <= '0;
      end else if (ce_i) begin
         if (tmo && !start) begin
            result_r <= acc_r;                                            // R02
         end
      end
   end

endmodule : ldnc_top

// ==== hw/ldnc_defs.svh ====
`ifndef LDNC_DEFS_SVH
`define LDNC_DEFS_SVH

// Register byte addresses
`define LDNC_A_CTRL     8'h00
`define LDNC_A_LDCFG    8'h04
`define LDNC_A_LDSTART  8'h08
`define LDNC_A_FREQ     8'h0c
`define LDNC_A_PHASE    8'h10
`define LDNC_A_FSTROBE  8'h14
`define LDNC_A_PSTROBE  8'h18
`define LDNC_A_RESULT   8'h1c
`define LDNC_A_STATUS   8'h20
`define LDNC_A_AFREQ    8'h24

// Carrier and input control field positions
`define LDNC_CTL_SYNC_EN  20
`define LDNC_CTL_IN_FMT   18
`define LDNC_CTL_IN_MODE  17
`define LDNC_CTL_CLR_ACC  2
`define LDNC_CTL_LOAD_UPD 0

// Level detector config and phase word layout
`define LDNC_CFG_MSB      30
`define LDNC_THR_MSB      13
`define LDNC_PO_MSB       9

// Counter and phase constants
`define LDNC_CNT_TC       18'h00004
`define LDNC_CNT_STEP     18'h00001
`define LDNC_CNT_LSB_PAD  2'h0
`define LDNC_PH_TOP       22

// Reset values
`define LDNC_RST_W32      32'h0000_0000
`define LDNC_RST_PO       10'h000
`define LDNC_RST_CNT      18'h00000

`endif

// ==== hw/ldnc_pkg.sv ====
package ldnc_pkg;

   // Level detector configuration word
   typedef struct packed {
      logic        mode;       // 1 = continuous
      logic [15:0] interval;   // Counter preload, upper bits
      logic [13:0] threshold;  // Signed threshold
   } ldnc_ld_cfg_t;

   // Carrier and input control bits
   typedef struct packed {
      logic sync_en;
      logic in_fmt;
      logic in_mode;
      logic clr_acc;
      logic load_upd;
   } ldnc_ctl_t;

   // Register index decoded from address
   typedef enum logic [3:0] {
      LDNC_R_CTRL, LDNC_R_LDCFG, LDNC_R_LDSTART, LDNC_R_FREQ,
      LDNC_R_PHASE, LDNC_R_FSTROBE, LDNC_R_PSTROBE, LDNC_R_RESULT,
      LDNC_R_STATUS, LDNC_R_AFREQ, LDNC_R_NONE
   } ldnc_reg_t;

   // Level detector states, Gray along the path
   typedef enum logic [1:0] {
      LDNC_IDLE = 2'h0,
      LDNC_RUN  = 2'h1,
      LDNC_DONE = 2'h3
   } ldnc_state_t;

endpackage : ldnc_pkg

// ==== bench/ldnc_properties.sv ====
`timescale 1ns/10ps
`include "ldnc_defs.svh"

module ldnc_properties
   import ldnc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock, reset, enable
   input wire logic              core_clk_i,
   input wire logic              sys_rst_i,
   input wire logic              ce_i,
   // APB side
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   // Sample side and results
   input wire logic              input_enable_n_i,
   input wire logic [9:0]        carrier_phase_o,
   input wire logic              level_busy_o
);
   logic wr_done;
   logic start_wr;
   logic mode_r;

   // Completed writes
   assign wr_done  = psel_i && penable_i && pwrite_i && pready_o && ce_i;
   assign start_wr = wr_done && (paddr_i == `LDNC_A_LDSTART);

   // Integration mode as last written
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         mode_r <= 1'h0;
      end else if (wr_done && paddr_i == `LDNC_A_LDCFG) begin
         mode_r <= pwdata_i[`LDNC_CFG_MSB];
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_start_busy: assert property (start_wr |=> level_busy_o)
      else $error("start write did not raise busy");
   a_busy_cause: assert property ($rose(level_busy_o) |-> $past(start_wr))
      else $error("busy rose without a start write");
   a_cont_run: assert property (mode_r && $past(mode_r) && $past(level_busy_o) |-> level_busy_o)
      else $error("continuous integration stopped");
   a_osc_hold: assert property ((input_enable_n_i && !psel_i)[*2] |=> $stable(carrier_phase_o))
      else $error("carrier phase moved while not enabled");
   a_ready_answer: assert property ($rose(penable_i) && psel_i && ce_i |=> pready_o)
      else $error("pready late");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_bad_addr: assert property (pready_o && !pwrite_i && paddr_i > `LDNC_A_AFREQ |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped read not refused");
   a_good_addr: assert property (pready_o && paddr_i <= `LDNC_A_AFREQ && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
      else $error("mapped access refused");

   // Main scenarios
   c_start: cover property (start_wr);
   c_one_shot_end: cover property ($fell(level_busy_o));
   c_refused: cover property (pready_o && pslverr_o);
endmodule : ldnc_properties

bind ldnc_top ldnc_properties #(.ADDR_W(ADDR_W)) i_ldnc_properties (.core_clk_i, .sys_rst_i, .ce_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .input_enable_n_i,
   .carrier_phase_o, .level_busy_o);

// ==== bench/ldnc_partner.sv ====
`timescale 1ns/10ps

module ldnc_partner (
   // Controls from the bench
   input  wire logic        gate_i,
   input  wire logic        sync_req_i,
   input  wire logic [13:0] level_i,
   // Pins into the block
   output logic      [13:0] sample_o,
   output logic             input_enable_n_o,
   output logic             sync_o
);
   // Enable and sync follow the bench, which drives them on the clock edge
   assign input_enable_n_o = gate_i;
   assign sync_o           = sync_req_i;
   // Junk while not enabled, so a gated design must hold its own copy
   assign sample_o = gate_i ? ~level_i : level_i;
endmodule : ldnc_partner

// ==== bench/test_ldnc_top.sv ====
`timescale 1ns/10ps
`include "ldnc_defs.svh"

module test_ldnc_top;
   logic        clk      = 1'h0;
   logic        rst      = 1'h1;
   logic        psel     = 1'h0;
   logic        penable  = 1'h0;
   logic        pwrite   = 1'h0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic        gate     = 1'h0;
   logic        toggle   = 1'h0;
   logic        gate_set = 1'h0;
   logic        sync_req = 1'h0;
   logic [13:0] level    = 14'h0;
   logic [31:0] prdata, rd;
   logic [13:0] sample;
   logic [9:0]  phase;
   logic        pready, pslverr, perr, busy, en_n, sync;
   int          err_total = 0;
   int          check_count = 0;
   int          n;

   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end

   // Enable pin: alternating for gated and interpolated runs, else as set
   always @(posedge clk) begin
      if (toggle) gate <= ~gate;
      else gate <= gate_set;
   end

   ldnc_partner i_ldnc_partner (.gate_i(gate), .sync_req_i(sync_req), .level_i(level), .sample_o(sample),
      .input_enable_n_o(en_n), .sync_o(sync));
   ldnc_top i_ldnc_top (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(1'h1), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sample_i(sample), .input_enable_n_i(en_n), .front_end_sync_input_i(sync),
      .carrier_phase_o(phase), .level_busy_o(busy));

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         chk("pready", 32'h1, 32'h0);
         wrap_up();
      end
   endtask : apb

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk

   task automatic pulse_sync;
      @(posedge clk);
      sync_req <= 1'h1;
      @(posedge clk);
      sync_req <= 1'h0;
   endtask : pulse_sync

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      rdchk("afreq", `LDNC_A_AFREQ, 32'h0);
      apb(1'h0, 8'h40, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, perr});
      $display("Test reset done");
      apb(1'h1, `LDNC_A_PHASE, 32'h0000_02c5);
      repeat (2) @(posedge clk);
      chk("phase held", 32'h0, {22'h0, phase});
      apb(1'h1, `LDNC_A_PSTROBE, 32'h0);
      repeat (2) @(posedge clk);
      chk("phase active", 32'h2c5, {22'h0, phase});
      rdchk("status", `LDNC_A_STATUS, 32'h2);
      $display("Test phase strobe done");
      apb(1'h1, `LDNC_A_FREQ, 32'h89ab_cdef);
      rdchk("afreq held", `LDNC_A_AFREQ, 32'h0);
      apb(1'h1, `LDNC_A_FSTROBE, 32'h0);
      rdchk("afreq strobe", `LDNC_A_AFREQ, 32'h89ab_cdef);
      $display("Test frequency strobe done");
      apb(1'h1, `LDNC_A_FREQ, 32'h0000_1000);
      apb(1'h1, `LDNC_A_PHASE, 32'h0000_00f0);
      pulse_sync();
      rdchk("afreq no sync", `LDNC_A_AFREQ, 32'h89ab_cdef);
      apb(1'h1, `LDNC_A_CTRL, 32'h0010_0000);
      gate_set <= 1'h1;
      pulse_sync();
      repeat (12) @(posedge clk);
      rdchk("afreq pending", `LDNC_A_AFREQ, 32'h89ab_cdef);
      rdchk("status pending", `LDNC_A_STATUS, 32'h12);
      gate_set <= 1'h0;
      repeat (3) @(posedge clk);
      rdchk("afreq synced", `LDNC_A_AFREQ, 32'h0000_1000);
      rdchk("status synced", `LDNC_A_STATUS, 32'h0);
      $display("Test sync done");
      level <= 14'h3f9c;
      toggle <= 1'h1;
      apb(1'h1, `LDNC_A_LDCFG, {2'h0, 16'h0003, 14'h3ffb});
      apb(1'h1, `LDNC_A_LDSTART, 32'h5555_aaaa);
      n = 0;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk);
         if (busy === 1'h1) n++;
      end
      chk("busy cycles", 32'd9, 32'(n));
      rdchk("result gated", `LDNC_A_RESULT, 32'h0000_02f8);
      $display("Test one-shot done");
      apb(1'h1, `LDNC_A_CTRL, 32'h0012_0000);
      apb(1'h1, `LDNC_A_LDCFG, {2'h1, 16'h0003, 14'h3ffb});
      apb(1'h1, `LDNC_A_LDSTART, 32'h0);
      repeat (40) @(posedge clk);
      chk("busy cont", 32'h1, {31'h0, busy});
      rdchk("result interp", `LDNC_A_RESULT, 32'h0000_0168);
      $display("Test continuous done");
      toggle <= 1'h0;
      apb(1'h1, `LDNC_A_FREQ, 32'h4000_0000);
      apb(1'h1, `LDNC_A_FSTROBE, 32'h0);
      apb(1'h1, `LDNC_A_CTRL, 32'h0004_0001);
      apb(1'h1, `LDNC_A_FSTROBE, 32'h0);
      @(posedge clk);
      chk("phase reload", 32'h0f0, {22'h0, phase});
      @(posedge clk);
      chk("phase step", 32'h1f0, {22'h0, phase});
      apb(1'h1, `LDNC_A_CTRL, 32'h0004_0004);
      repeat (2) @(posedge clk);
      chk("phase cleared", 32'h0f0, {22'h0, phase});
      @(posedge clk);
      chk("phase still cleared", 32'h0f0, {22'h0, phase});
      $display("Test load on update done");
      level <= 14'h1f9c;
      apb(1'h1, `LDNC_A_LDCFG, {2'h0, 16'h0003, 14'h3ffb});
      apb(1'h1, `LDNC_A_LDSTART, 32'h0);
      repeat (12) @(posedge clk);
      rdchk("result offset", `LDNC_A_RESULT, 32'h0000_02f8);
      $display("Test offset binary done");
      wrap_up();
   end
endmodule : test_ldnc_top
